// file: i2cr_slave.sv
// Behaviour
// - START while receiving returns to address wait.
// - Master not acknowledging read byte returns slave to idle, data kept.
// - STOP ends transaction; idle until next START.
// - Recovery resets serial machine only, data kept.
// - Frames: write 29, read 39, 20+9N bits.
// - Read-address presence test acknowledged with zero.
// - Clock and data pins only pull low.
`timescale 1ns/1ps
`default_nettype none
`include "i2cr_map.svh"

module i2cr_slave
	import i2cr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic scl_i,
	output var logic scl_o,
	output var logic scl_oe_n,
	input wire logic sda_i,
	output var logic sda_o,
	output var logic sda_oe_n,
	output var logic [7:0] code_out,
	output var logic code_upd,
	output var logic link_busy
);

	// Link domain: pin synchronisers, stages 1 and 2 plus a history stage.
	logic [2:0] scl_sy_r, scl_sy_nxt; // Bit 0 is the first stage, read only by bit 1.
	logic [2:0] sda_sy_r, sda_sy_nxt; // Same structure for the data line.
	i2cr_ev_type ev; // Decoded bus events for this link cycle.

	// Link domain: serial machine state.
	i2cr_state_type st_r, st_nxt; // Interface state.
	logic [3:0] cnt_r, cnt_nxt; // Bits shifted in this byte slot.
	logic [7:0] sh_r, sh_nxt; // Receive and transmit shift register.
	logic [7:0] cmd_r, cmd_nxt; // Last command byte.
	logic rw_r, rw_nxt; // Direction bit of the last matching address.
	logic [7:0] pend_r, pend_nxt; // Data byte waiting for a STOP.
	logic pend_v_r, pend_v_nxt; // Pending byte is valid.
	logic [7:0] lval_r, lval_nxt; // Link-side copy of the committed code, used for reads.
	logic wtgl_r, wtgl_nxt; // Toggles once per committed write.
	logic oe_n_r, oe_n_nxt; // Data line release, low while pulling low.
	logic busy_r, busy_nxt; // Transaction in progress.

	// System domain: crossing of the commit toggle and busy level.
	logic [2:0] tsy_r, tsy_nxt; // Toggle synchroniser plus history stage.
	logic [1:0] bsy_r, bsy_nxt; // Busy level synchroniser.
	logic [7:0] code_r, code_nxt; // Output code register.
	logic upd_r, upd_nxt; // One-cycle update strobe.

	// Event decode reads only stages 2 and 3, never the first stage.
	always_comb begin
		ev.rise = scl_sy_r[1] & ~scl_sy_r[2];
		ev.fall = ~scl_sy_r[1] & scl_sy_r[2];
		ev.start = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
		ev.stop = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
		ev.sda = sda_sy_r[1];
	end

	// Next state of the link-side machine.
	// The link clock runs free, so the pins are oversampled rather than used as clocks.
	always_comb begin
		scl_sy_nxt = {scl_sy_r[1:0], scl_i};
		sda_sy_nxt = {sda_sy_r[1:0], sda_i};
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		cmd_nxt = cmd_r;
		rw_nxt = rw_r;
		pend_nxt = pend_r;
		pend_v_nxt = pend_v_r;
		lval_nxt = lval_r;
		wtgl_nxt = wtgl_r;
		oe_n_nxt = oe_n_r;
		busy_nxt = busy_r;
		if (ev.start) begin
			// Any START, repeated or not, restarts address reception.
			// A byte not yet closed by a STOP is dropped, so an aborted write never lands.
			st_nxt = I2CR_ADDR;
			cnt_nxt = 4'h0;
			oe_n_nxt = 1'b1;
			pend_v_nxt = 1'b0;
			busy_nxt = 1'b1;
		end else if (ev.stop) begin
			// STOP ends the transaction and commits a complete data byte armed by the write command.
			st_nxt = I2CR_IDLE;
			oe_n_nxt = 1'b1;
			busy_nxt = 1'b0;
			pend_v_nxt = 1'b0;
			if (pend_v_r) begin
				lval_nxt = pend_r;
				wtgl_nxt = ~wtgl_r;
			end
		end else begin
			case (st_r)
				I2CR_IDLE: begin
					// Ignore everything until a START is seen.
					oe_n_nxt = 1'b1;
				end
				I2CR_ADDR, I2CR_CMD, I2CR_WDATA: begin
					// Eight data bits, then the acknowledge bit, give nine per byte.
					if (ev.rise && cnt_r != `I2CR_BYTE_BITS) begin
						sh_nxt = {sh_r[6:0], ev.sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (ev.fall && cnt_r == `I2CR_BYTE_BITS) begin
						if (st_r == I2CR_ADDR) begin
							if (sh_r[7:1] == `I2CR_SLAVE_ADDR) begin
								// Matching address, including a read-only presence test, gets ACK 0.
								st_nxt = I2CR_ADDR_ACK;
								rw_nxt = sh_r[0];
								oe_n_nxt = 1'b0;
							end else begin
								st_nxt = I2CR_IDLE;
								busy_nxt = 1'b0;
							end
						end else if (st_r == I2CR_CMD) begin
							cmd_nxt = sh_r;
							st_nxt = I2CR_CMD_ACK;
							oe_n_nxt = 1'b0;
						end else begin
							// Only the write command arms a commit of the data byte.
							pend_nxt = sh_r;
							pend_v_nxt = (cmd_r == `I2CR_CMD_WRITE);
							st_nxt = I2CR_WDATA_ACK;
							oe_n_nxt = 1'b0;
						end
					end
				end
				I2CR_ADDR_ACK: begin
					if (ev.fall) begin
						cnt_nxt = 4'h0;
						if (rw_r) begin
							// Present the first read bit as soon as the acknowledge ends.
							st_nxt = I2CR_RDATA;
							sh_nxt = lval_r;
							oe_n_nxt = lval_r[7];
							cnt_nxt = 4'h1;
						end else begin
							st_nxt = I2CR_CMD;
							oe_n_nxt = 1'b1;
						end
					end
				end
				I2CR_CMD_ACK, I2CR_WDATA_ACK: begin
					if (ev.fall) begin
						st_nxt = I2CR_WDATA;
						cnt_nxt = 4'h0;
						oe_n_nxt = 1'b1;
					end
				end
				I2CR_RDATA: begin
					if (ev.fall) begin
						if (cnt_r == `I2CR_BYTE_BITS) begin
							// Let go of the line for the master's acknowledge.
							st_nxt = I2CR_RDATA_ACK;
							oe_n_nxt = 1'b1;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_n_nxt = sh_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				I2CR_RDATA_ACK: begin
					if (ev.rise) begin
						if (ev.sda) begin
							// A not-acknowledged byte drops the machine back to idle.
							st_nxt = I2CR_IDLE;
							busy_nxt = 1'b0;
						end else begin
							st_nxt = I2CR_RDATA_MORE;
						end
					end
				end
				I2CR_RDATA_MORE: begin
					if (ev.fall) begin
						st_nxt = I2CR_RDATA;
						sh_nxt = lval_r;
						oe_n_nxt = lval_r[7];
						cnt_nxt = 4'h1;
					end
				end
				default: begin
					st_nxt = I2CR_IDLE;
					oe_n_nxt = 1'b1;
				end
			endcase
		end
	end

	// Link-side registers. Recovery only moves the machine; lval_r changes on commit only.
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
			st_r <= I2CR_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			rw_r <= 1'b0;
			pend_r <= 8'h00;
			pend_v_r <= 1'b0;
			lval_r <= `I2CR_CODE_RST;
			wtgl_r <= 1'b0;
			oe_n_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			scl_sy_r <= scl_sy_nxt;
			sda_sy_r <= sda_sy_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			cmd_r <= cmd_nxt;
			rw_r <= rw_nxt;
			pend_r <= pend_nxt;
			pend_v_r <= pend_v_nxt;
			lval_r <= lval_nxt;
			wtgl_r <= wtgl_nxt;
			oe_n_r <= oe_n_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Pin drivers: the output value is fixed low, only the enable moves.
	// The clock line is never stretched, so its enable stays released.
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
			scl_oe_n <= 1'b1;
		end else begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
			scl_oe_n <= 1'b1;
		end
	end
	assign sda_oe_n = oe_n_r;

	// System side next values. lval_r is stable long before the toggle is seen,
	// because commits are at least one whole frame apart.
	always_comb begin
		tsy_nxt = {tsy_r[1:0], wtgl_r};
		bsy_nxt = {bsy_r[0], busy_r};
		code_nxt = code_r;
		upd_nxt = 1'b0;
		if (tsy_r[1] != tsy_r[2]) begin
			code_nxt = lval_r;
			upd_nxt = 1'b1;
		end
	end

	// System side registers.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tsy_r <= 3'h0;
			bsy_r <= 2'h0;
			code_r <= `I2CR_CODE_RST;
			upd_r <= 1'b0;
		end else begin
			tsy_r <= tsy_nxt;
			bsy_r <= bsy_nxt;
			code_r <= code_nxt;
			upd_r <= upd_nxt;
		end
	end

	assign code_out = code_r;
	assign code_upd = upd_r;
	assign link_busy = bsy_r[1];

endmodule : i2cr_slave

`default_nettype wire

// file: i2cr_map.svh
`ifndef I2CR_MAP_SVH
`define I2CR_MAP_SVH

// Seven-bit bus address of this slave; the value is arbitrary.
`define I2CR_SLAVE_ADDR 7'h2a
// Command byte that makes the following data bytes update the output code.
`define I2CR_CMD_WRITE 8'h00
// Value of the output code register after reset.
`define I2CR_CODE_RST 8'h40
// Bits in one byte slot before its acknowledge bit.
`define I2CR_BYTE_BITS 4'h8
// Frame lengths in bit times, START and STOP counted.
`define I2CR_FRAME_WR1 29
`define I2CR_FRAME_RD1 39
`define I2CR_FRAME_WRN_BASE 20
`define I2CR_FRAME_WRN_PER 9

`endif

// file: i2cr_pkg.sv
`default_nettype none
package i2cr_pkg;

	// States of the serial interface machine.
	typedef enum logic [3:0] {
		I2CR_IDLE,
		I2CR_ADDR,
		I2CR_ADDR_ACK,
		I2CR_CMD,
		I2CR_CMD_ACK,
		I2CR_WDATA,
		I2CR_WDATA_ACK,
		I2CR_RDATA,
		I2CR_RDATA_ACK,
		I2CR_RDATA_MORE
	} i2cr_state_type;

	// Bus events decoded from the synchronised pins.
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} i2cr_ev_type;

endpackage : i2cr_pkg

`default_nettype wire

// file: i2cr_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Pin and output-code checks on the slave.
module i2cr_slave_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic [7:0] code_out,
	input wire logic code_upd,
	input wire logic link_busy
);
	// A pull on data may only begin while the clock line is low.
	sequence s_pull;
		$fell(sda_oe_n);
	endsequence
	// Once begun, the pull lasts at least seven more link clocks.
	sequence s_pull_held;
		!scl_i ##1 !sda_oe_n [*7];
	endsequence
	sequence s_start;
		scl_i && $fell(sda_i);
	endsequence
	chk_scl_free: assert property (@(posedge link_clk) disable iff (!nrst) scl_oe_n && !scl_o)
		else $error("clock pin driven");
	chk_sda_low: assert property (@(posedge link_clk) disable iff (!nrst) !sda_oe_n |-> !sda_o)
		else $error("data pin driven high");
	chk_pull_hold: assert property (@(posedge link_clk) disable iff (!nrst)
		s_pull |-> s_pull_held) else $error("pull cut short or begun with clock high");
	chk_start_quiet: assert property (@(posedge link_clk) disable iff (!nrst)
		s_start |-> sda_oe_n [*8]) else $error("slave drives after start");
	chk_stop_quiet: assert property (@(posedge link_clk) disable iff (!nrst)
		scl_i && $rose(sda_i) |-> sda_oe_n [*8]) else $error("slave drives after stop");
	chk_upd_pulse: assert property (@(posedge clk) disable iff (!nrst)
		code_upd |=> !code_upd) else $error("update pulse too long");
	chk_code_hold: assert property (@(posedge clk) disable iff (!nrst)
		!code_upd |-> $stable(code_out)) else $error("code moved without update");
	chk_upd_idle: assert property (@(posedge clk) disable iff (!nrst)
		code_upd |-> ##[0:8] !link_busy) else $error("commit while busy");
endmodule : i2cr_slave_chk
bind i2cr_slave i2cr_slave_chk u_chk (.clk(clk), .nrst(nrst), .link_clk(link_clk),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n(sda_oe_n), .code_out(code_out), .code_upd(code_upd), .link_busy(link_busy));
`default_nettype wire

// file: i2cr_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model; it pulls its lines low or lets the pull-up win.
module i2cr_master (
	input wire logic clk,
	input wire logic sda_w,
	output var logic scl_m,
	output var logic sda_m
);
	int nbits = 0; // Bit times in the current frame.
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Ten clocks a phase keep every edge far from the slave's sampling lag.
	task automatic ph(input logic c, input logic d);
		scl_m <= c;
		sda_m <= d;
		repeat (10) @(posedge clk);
	endtask : ph
	task automatic start();
		ph(scl_m, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		nbits++;
	endtask : start
	task automatic stop();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		nbits++;
	endtask : stop
	// The wire is sampled late in the high phase.
	task automatic tx(input logic b, output logic r);
		ph(1'b0, b);
		ph(1'b1, b);
		r = sda_w;
		ph(1'b0, b);
		nbits++;
	endtask : tx
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
		output logic k);
		for (int i = 7; i >= 0; i--) tx(d[i], r[i]);
		tx(a, k);
	endtask : xfer
endmodule : i2cr_master
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cr_map.svh"
module tb_top;
	logic clk, link_clk, nrst, scl_m, sda_m, scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic code_upd, link_busy, ack;
	logic [7:0] code_out, rd;
	logic [31:0] rng = 32'h3d646b4e;
	int err_total, tests_run, exp_code;
	int upd_seen = 0, upd_exp = 0; // Commit strobes seen and expected.
	// Open-drain wires with pull-ups.
	wire logic scl_w = scl_m & (scl_oe_n | scl_o);
	wire logic sda_w = sda_m & (sda_oe_n | sda_o);
	i2cr_slave dut_u (.clk(clk), .nrst(nrst), .link_clk(link_clk), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .code_out(code_out), .code_upd(code_upd),
		.link_busy(link_busy));
	i2cr_master u_m (.clk(clk), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
	// Strobes are counted, so a commit that repeats the old code is still seen.
	always @(posedge clk) begin
		if (code_upd === 1'b1) begin
			upd_seen++;
		end
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic adr(input logic rw);
		u_m.start();
		u_m.xfer({`I2CR_SLAVE_ADDR, rw}, 1'b1, rd, ack);
		check("addr ack", {7'h00, ack}, 8'h00);
	endtask : adr
	// The bench model: the last whole data byte of a clean frame becomes the code.
	task automatic wr(input int k);
		u_m.nbits = 0;
		adr(1'b0);
		u_m.xfer(`I2CR_CMD_WRITE, 1'b1, rd, ack);
		repeat (k) begin
			rng = xs(rng);
			exp_code = rng[7:0];
			u_m.xfer(rng[7:0], 1'b1, rd, ack);
		end
		u_m.stop();
		check("bits", 8'(u_m.nbits), 8'(20 + k * 9));
		repeat (20) @(posedge clk);
		check("code", code_out, 8'(exp_code));
		upd_exp++;
		check("commits", 8'(upd_seen), 8'(upd_exp));
		$display("write of %0d bytes done", k);
	endtask : wr
	task automatic recover();
		u_m.start();
		repeat (9) u_m.tx(1'b1, ack);
		u_m.start();
		u_m.stop();
		repeat (20) @(posedge clk);
		check("code kept", code_out, 8'(exp_code));
		check("idle", {7'h00, link_busy}, 8'h00);
		check("no commit", 8'(upd_seen), 8'(upd_exp));
		$display("recovery done");
	endtask : recover
	initial begin
		nrst = 1'b0;
		err_total = 0;
		tests_run = 0;
		exp_code = `I2CR_CODE_RST;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		check("reset code", code_out, `I2CR_CODE_RST);
		wr(1);
		wr(3);
		u_m.nbits = 0;
		adr(1'b0);
		u_m.xfer(`I2CR_CMD_WRITE, 1'b1, rd, ack);
		adr(1'b1);
		u_m.xfer(8'hff, 1'b1, rd, ack);
		check("nak idle", {7'h00, link_busy}, 8'h00);
		u_m.stop();
		check("read bits", 8'(u_m.nbits), 8'h27);
		check("read data", rd, 8'(exp_code));
		$display("read done");
		u_m.start();
		repeat (4) u_m.tx(1'b0, ack);
		wr(1);
		u_m.start();
		u_m.xfer(8'h56, 1'b1, rd, ack);
		check("foreign addr", {7'h00, ack}, 8'h01);
		u_m.stop();
		// A command other than the write command takes data but never commits it.
		adr(1'b0);
		u_m.xfer(`I2CR_CMD_WRITE ^ 8'h01, 1'b1, rd, ack);
		u_m.xfer(~8'(exp_code), 1'b1, rd, ack);
		check("data ack", {7'h00, ack}, 8'h00);
		u_m.stop();
		repeat (20) @(posedge clk);
		check("other cmd", code_out, 8'(exp_code));
		check("other commits", 8'(upd_seen), 8'(upd_exp));
		$display("other command done");
		adr(1'b1);
		// The master acknowledges one byte, so the same code is sent again.
		u_m.xfer(8'hff, 1'b0, rd, ack);
		check("read more", rd, 8'(exp_code));
		recover();
		adr(1'b0);
		u_m.xfer(`I2CR_CMD_WRITE, 1'b1, rd, ack);
		rng = xs(rng);
		for (int i = 7; i >= 0; i--) u_m.tx(rng[i], ack);
		recover();
		wr(1);
		test_done();
	end
	// A hang is cut short well past the expected run of about nine thousand clocks.
	initial begin
		#1000000;
		err_total++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
